//--- logic/stx_defs.vh
// Constants for the skip, table read and exclusive-or execution block
`ifndef STX_DEFS_VH
`define STX_DEFS_VH

// Register byte addresses
`define STX_A_CMD        13'h0000
`define STX_A_ACC        13'h0004
`define STX_A_STAT       13'h0008
`define STX_A_TPLO       13'h000c
`define STX_A_TPHI       13'h0010
`define STX_A_TLATCH     13'h0014
`define STX_A_PAGE       13'h0018
`define STX_A_DMEM_LO    13'h0400
`define STX_A_DMEM_HI    13'h04fc
`define STX_A_PMEM_LO    13'h1000
`define STX_A_PMEM_HI    13'h1ffc

// Command fields
`define STX_F_OP         3:0
`define STX_F_MADDR      9:4
`define STX_F_BIT        14:12
`define STX_F_IMM        23:16

// Word index fields of bus addresses
`define STX_F_DIX        7:2
`define STX_F_PIX        11:2

// Status bits
`define STX_S_ZERO       0
`define STX_S_SKIP       1
`define STX_S_BUSY       2

// Operation codes
`define STX_OP_SWAP      4'h1
`define STX_OP_SKNULL    4'h2
`define STX_OP_CPSKIP    4'h3
`define STX_OP_BITSKIP   4'h4
`define STX_OP_TBPAGED   4'h5
`define STX_OP_TBCUR     4'h6
`define STX_OP_TBLAST    4'h7
`define STX_OP_XORACC    4'h8
`define STX_OP_XORMEM    4'h9
`define STX_OP_XORIMM    4'ha

// Sizes and reset values
`define STX_DMEM_WORDS   64
`define STX_PMEM_WORDS   1024
`define STX_LAST_PAGE    2'h3
`define STX_ICYC_CLKS    2'h3
`define STX_ZERO8        8'h00

`endif

//--- logic/stx_exec.v
// Execution unit for nibble exchange, skips, table reads and exclusive-or
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "stx_defs.vh"

module stx_exec (
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire [12:0] avm_address_i,
   input  wire        avm_read_i,
   input  wire        avm_write_i,
   input  wire [31:0] avm_writedata_i,
   input  wire [3:0]  avm_byteenable_i,
   output reg  [31:0] avm_readdata_o,
   output reg         avm_waitrequest_o,
   output reg         busy_o,
   output reg         skip_o
);

   // Execution states
   // ST_DUMMY stands for the fetch slot that a taken skip discards
   localparam ST_IDLE  = 2'b00;
   localparam ST_EXEC  = 2'b01;
   localparam ST_DUMMY = 2'b10;

   // Memories
   reg [7:0]  dmem [0:`STX_DMEM_WORDS-1];
   reg [15:0] pmem [0:`STX_PMEM_WORDS-1];

   // Architectural registers
   // Page fields are two bits wide: four pages of 256 program words
   reg [7:0]  acc_r;
   reg        zero_r;
   reg [7:0]  tplo_r;
   reg [1:0]  tphi_r;
   reg [7:0]  tlatch_r;
   reg [1:0]  page_r;

   // Command latched at start
   reg [3:0]  op_r;
   reg [5:0]  maddr_r;
   reg [2:0]  bit_r;
   reg [7:0]  imm_r;

   // Sequencer
   // cyc_en is a one-clock pulse, never a derived clock
   reg [1:0]  state_r;
   reg [1:0]  div_r;
   reg        cyc_en;

   // Execution results
   reg [7:0]  acc_nxt;
   reg        zero_nxt;
   reg        skip_nxt;
   reg        dm_we;
   reg [7:0]  dm_wd;
   reg        tl_we;
   reg [9:0]  paddr;
   reg [7:0]  xr;

   // Bus decode
   reg        bus_go;
   reg        bus_wr;
   reg [31:0] rd_val;
   reg [31:0] wmask;

   // Operand, table word and bus word indices
   wire [7:0]  opnd  = dmem[maddr_r];
   wire [15:0] pword = pmem[paddr];
   wire [5:0]  b_dix = avm_address_i[`STX_F_DIX];
   wire [9:0]  b_pix = avm_address_i[`STX_F_PIX];

   // True when the address lies in an inclusive word range
   function in_rng;
      input [12:0] a;
      input [12:0] lo;
      input [12:0] hi;
      begin
         in_rng = (a >= lo) && (a <= hi) && (a[1:0] == 2'b00);
      end
   endfunction

   // Merge write data into a stored value under byte enables
   function [31:0] be_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer k;
      begin
         be_merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k]) begin
               be_merge[k*8 +: 8] = nw[k*8 +: 8];
            end
         end
      end
   endfunction

   // Byte-enable merges; only the low bytes reach their narrower targets
   wire [31:0] acc_mrg  = be_merge({24'h000000, acc_r},
                                   avm_writedata_i, avm_byteenable_i);
   wire [31:0] tplo_mrg = be_merge({24'h000000, tplo_r},
                                   avm_writedata_i, avm_byteenable_i);
   wire [31:0] pw_mrg   = be_merge({16'h0000, pmem[b_pix]},
                                   avm_writedata_i, avm_byteenable_i);

   // Instruction cycle enable from a clock divider
   // One pulse every four clocks while a command runs
   always @* begin
      cyc_en = (div_r == `STX_ICYC_CLKS);
   end

   // Program address for table reads
   // Current and last pages ignore the high pointer
   always @* begin
      paddr = {tphi_r, tplo_r};
      if (op_r == `STX_OP_TBCUR) begin
         paddr = {page_r, tplo_r};
      end else if (op_r == `STX_OP_TBLAST) begin
         paddr = {`STX_LAST_PAGE, tplo_r};
      end
   end

   // Operation results of the current command
   // Defaults leave every result as it was for unused opcodes
   always @* begin
      acc_nxt  = acc_r;
      zero_nxt = zero_r;
      skip_nxt = 1'b0;
      dm_we    = 1'b0;
      dm_wd    = opnd;
      tl_we    = 1'b0;
      xr       = acc_r ^ opnd;
      case (op_r)
         `STX_OP_SWAP: begin
            acc_nxt = {opnd[3:0], opnd[7:4]};
         end
         `STX_OP_SKNULL: begin
            skip_nxt = (opnd == `STX_ZERO8);
         end
         `STX_OP_CPSKIP: begin
            acc_nxt  = opnd;
            skip_nxt = (opnd == `STX_ZERO8);
         end
         `STX_OP_BITSKIP: begin
            skip_nxt = ~opnd[bit_r];
         end
         `STX_OP_TBPAGED, `STX_OP_TBCUR, `STX_OP_TBLAST: begin
            dm_we = 1'b1;
            dm_wd = pword[7:0];
            tl_we = 1'b1;
         end
         `STX_OP_XORACC: begin
            acc_nxt = xr;
         end
         `STX_OP_XORMEM: begin
            dm_we = 1'b1;
            dm_wd = xr;
         end
         `STX_OP_XORIMM: begin
            // Immediate replaces the memory operand
            // xor with immediate
            xr      = acc_r ^ imm_r;
            acc_nxt = xr;
         end
         default: begin
            acc_nxt = acc_r;
         end
      endcase
      if ((op_r == `STX_OP_XORACC) || (op_r == `STX_OP_XORMEM) ||
          (op_r == `STX_OP_XORIMM)) begin
         zero_nxt = (xr == `STX_ZERO8);
      end
   end

   // Bus request decode and read multiplexer
   // Writes are refused while busy so operands stay put
   always @* begin
      bus_go = (avm_read_i || avm_write_i) && avm_waitrequest_o;
      bus_wr = bus_go && avm_write_i && !busy_o;
      wmask  = be_merge(32'h0000_0000, avm_writedata_i, avm_byteenable_i);
      rd_val = 32'h0000_0000;
      if (avm_address_i == `STX_A_CMD) begin
         rd_val = {8'h00, imm_r, 1'b0, bit_r, 2'b00, maddr_r, op_r};
      end else if (avm_address_i == `STX_A_ACC) begin
         rd_val = {24'h000000, acc_r};
      end else if (avm_address_i == `STX_A_STAT) begin
         rd_val = {29'h0000_0000, busy_o, skip_o, zero_r};
      end else if (avm_address_i == `STX_A_TPLO) begin
         rd_val = {24'h000000, tplo_r};
      end else if (avm_address_i == `STX_A_TPHI) begin
         rd_val = {30'h0000_0000, tphi_r};
      end else if (avm_address_i == `STX_A_TLATCH) begin
         rd_val = {24'h000000, tlatch_r};
      end else if (avm_address_i == `STX_A_PAGE) begin
         rd_val = {30'h0000_0000, page_r};
      end else if (in_rng(avm_address_i, `STX_A_DMEM_LO,
                          `STX_A_DMEM_HI)) begin
         rd_val = {24'h000000, dmem[b_dix]};
      end else if (in_rng(avm_address_i, `STX_A_PMEM_LO,
                          `STX_A_PMEM_HI)) begin
         rd_val = {16'h0000, pmem[b_pix]};
      end
   end

   // Data memory, written by the bus when idle or by execution
   // Execution wins; a bus write is already refused while busy
   always @(posedge clk_sys_i) begin
      if (state_r == ST_EXEC && cyc_en && dm_we) begin
         dmem[maddr_r] <= dm_wd;
      end else if (bus_wr && avm_byteenable_i[0] &&
                   in_rng(avm_address_i, `STX_A_DMEM_LO,
                          `STX_A_DMEM_HI)) begin
         dmem[b_dix] <= avm_writedata_i[7:0];
      end
   end

   // Program memory, loaded over the bus
   always @(posedge clk_sys_i) begin
      if (bus_wr && in_rng(avm_address_i, `STX_A_PMEM_LO,
                           `STX_A_PMEM_HI)) begin
         pmem[b_pix] <= pw_mrg[15:0];
      end
   end

   // Bus handshake: one wait cycle then a one-cycle answer
   // waitrequest idles high, so every access costs two edges
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         avm_waitrequest_o <= 1'b1;
         avm_readdata_o    <= 32'h0000_0000;
      end else if (bus_go) begin
         avm_waitrequest_o <= 1'b0;
         avm_readdata_o    <= avm_read_i ? rd_val : 32'h0000_0000;
      end else begin
         avm_waitrequest_o <= 1'b1;
      end
   end

   // Instruction cycle divider, restarted by each command
   // Restarting it keeps every command on the same phase
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 2'b00;
      end else if (state_r == ST_IDLE) begin
         div_r <= 2'b00;
      end else begin
         div_r <= div_r + 2'b01;
      end
   end

   // Command start, sequencing and register updates
   // skip_o clears as a command starts, takes the skip result at the end of the cycle and then holds until the next
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_r  <= ST_IDLE;
         busy_o   <= 1'b0;
         skip_o   <= 1'b0;
         acc_r    <= `STX_ZERO8;
         zero_r   <= 1'b0;
         tplo_r   <= `STX_ZERO8;
         tphi_r   <= 2'b00;
         tlatch_r <= `STX_ZERO8;
         page_r   <= 2'b00;
         op_r     <= 4'h0;
         maddr_r  <= 6'h00;
         bit_r    <= 3'h0;
         imm_r    <= `STX_ZERO8;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (bus_wr && avm_address_i == `STX_A_CMD) begin
                  op_r    <= wmask[`STX_F_OP];
                  maddr_r <= wmask[`STX_F_MADDR];
                  bit_r   <= wmask[`STX_F_BIT];
                  imm_r   <= wmask[`STX_F_IMM];
                  skip_o  <= 1'b0;
                  busy_o  <= 1'b1;
                  state_r <= ST_EXEC;
               end else if (bus_wr && avm_address_i == `STX_A_ACC) begin
                  acc_r <= acc_mrg[7:0];
               end else if (bus_wr && avm_address_i == `STX_A_TPLO) begin
                  tplo_r <= tplo_mrg[7:0];
               end else if (bus_wr && avm_address_i == `STX_A_TPHI) begin
                  // Only byte lane 0 carries the two-bit page fields
                  if (avm_byteenable_i[0]) begin
                     tphi_r <= avm_writedata_i[1:0];
                  end
               end else if (bus_wr && avm_address_i == `STX_A_PAGE) begin
                  if (avm_byteenable_i[0]) begin
                     page_r <= avm_writedata_i[1:0];
                  end
               end else if (bus_wr && avm_address_i == `STX_A_STAT) begin
                  if (avm_byteenable_i[0]) begin
                     zero_r <= avm_writedata_i[`STX_S_ZERO];
                  end
               end
            end
            ST_EXEC: begin
               // All results land together on the edge ending the cycle
               if (cyc_en) begin
                  acc_r  <= acc_nxt;
                  zero_r <= zero_nxt;
                  skip_o <= skip_nxt;
                  if (tl_we) begin
                     tlatch_r <= pword[15:8];
                  end
                  if (skip_nxt) begin
                     state_r <= ST_DUMMY;
                  end else begin
                     busy_o  <= 1'b0;
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_DUMMY: begin
               if (cyc_en) begin
                  busy_o  <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               busy_o  <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // stx_exec

//--- testbench/stx_bus_host.sv
// Avalon-MM host model that drives the execution block's register bus
`timescale 1ns/1ns
module stx_bus_host (
   input  wire        clk_sys_i,
   output reg  [12:0] avm_address_o,
   output reg         avm_read_o,
   output reg         avm_write_o,
   output reg  [31:0] avm_writedata_o,
   output reg  [3:0]  avm_byteenable_o,
   input  wire [31:0] avm_readdata_i,
   input  wire        avm_waitrequest_i
);
   // Idle bus from time zero
   initial begin
      avm_address_o = 13'h0000;
      avm_read_o = 1'b0;
      avm_write_o = 1'b0;
      avm_writedata_o = 32'h0;
      avm_byteenable_o = 4'hf;
   end
   // One access, held until waitrequest is sampled low
   task xfer(input w, input [12:0] a, input [31:0] d, output [31:0] q);
      begin
         @(posedge clk_sys_i);
         avm_address_o <= a;
         avm_writedata_o <= d;
         avm_write_o <= w;
         avm_read_o <= !w;
         @(posedge clk_sys_i);
         while (avm_waitrequest_i !== 1'b0) @(posedge clk_sys_i);
         q = avm_readdata_i;
         avm_read_o <= 1'b0;
         avm_write_o <= 1'b0;
         // Released lines show the inverse, not a stale value
         avm_address_o <= ~a;
         avm_writedata_o <= ~d;
      end
   endtask
endmodule // stx_bus_host

//--- testbench/stx_exec_sva.sv
// Port assertions for the execution block
`timescale 1ns/1ns
module stx_exec_sva (
   input wire        clk_sys_i,
   input wire        rst_i,
   input wire [12:0] avm_address_i,
   input wire        avm_read_i,
   input wire        avm_write_i,
   input wire [31:0] avm_readdata_o,
   input wire        avm_waitrequest_o,
   input wire        busy_o,
   input wire        skip_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   // Request and unmapped address decode
   wire req = avm_read_i || avm_write_i;
   wire hole = (avm_address_i >= 13'h001c && avm_address_i < 13'h0400) ||
               (avm_address_i >= 13'h0500 && avm_address_i < 13'h1000);
   // Bus answer timing and read data, command start, instruction cycle length and skip hold
   AST_ACK_ONE: assert property (req && avm_waitrequest_o
      |=> !avm_waitrequest_o)
      else $error("no answer one cycle after request");
   AST_ACK_PULSE: assert property (!avm_waitrequest_o |=> avm_waitrequest_o)
      else $error("answer longer than one cycle");
   AST_ACK_CAUSE: assert property (!avm_waitrequest_o |-> $past(req))
      else $error("answer without request");
   AST_RD_HOLD: assert property (avm_waitrequest_o && $past(avm_waitrequest_o)
      |-> $stable(avm_readdata_o)) else $error("read data moved");
   AST_HOLE: assert property (avm_read_i && !avm_waitrequest_o && hole
      |-> avm_readdata_o == 32'h0) else $error("unmapped read not zero");
   AST_START: assert property (
      avm_write_i && avm_waitrequest_o && !busy_o && avm_address_i == 13'h0
      |-> ##[1:2] busy_o) else $error("command did not start");
   AST_IDLE: assert property (!busy_o && !avm_write_i |=> !busy_o)
      else $error("busy without command");
   AST_ICYC: assert property ($rose(busy_o) |->
      (!skip_o && busy_o) ##1 busy_o[*3] ##1 (busy_o == skip_o))
      else $error("instruction cycle length wrong");
   AST_SKIP_HOLD: assert property (!busy_o |-> $stable(skip_o))
      else $error("skip moved while idle");
endmodule // stx_exec_sva
bind stx_exec stx_exec_sva chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .avm_address_i(avm_address_i), .avm_read_i(avm_read_i),
   .avm_write_i(avm_write_i), .avm_readdata_o(avm_readdata_o),
   .avm_waitrequest_o(avm_waitrequest_o), .busy_o(busy_o), .skip_o(skip_o));

//--- testbench/testbench.sv
// Self-checking bench for the execution block
`timescale 1ns/1ns
`include "stx_defs.vh"
module testbench;
   localparam LIMIT = 20000;
   reg         clk_sys_i = 1'b0;
   reg         rst_i     = 1'b1;
   wire [12:0] adr;
   wire        rds, wrs, wts, bsy, skp;
   wire [31:0] wd, rdat;
   wire [3:0]  be;
   reg  [31:0] q;
   reg  [15:0] pm [0:1023];
   reg  [15:0] pw;
   reg  [9:0]  pa;
   reg  [7:0]  acc, d, imm, tp, la, exa, exd;
   reg  [5:0]  ma;
   reg  [3:0]  op;
   reg  [2:0]  bi;
   reg  [1:0]  ph, pg;
   reg         z, exz, exs;
   integer     i, k, r, bcnt, cyc, bad_count, num_checks;
   // Clock at 100 MHz
   always #5 clk_sys_i = ~clk_sys_i;
   stx_exec dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avm_address_i(adr),
      .avm_read_i(rds), .avm_write_i(wrs), .avm_writedata_i(wd),
      .avm_byteenable_i(be), .avm_readdata_o(rdat),
      .avm_waitrequest_o(wts), .busy_o(bsy), .skip_o(skp));
   stx_bus_host bus_u (.clk_sys_i(clk_sys_i), .avm_address_o(adr),
      .avm_read_o(rds), .avm_write_o(wrs), .avm_writedata_o(wd),
      .avm_byteenable_o(be), .avm_readdata_i(rdat), .avm_waitrequest_i(wts));
   // Busy cycle count and run limit
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (bsy)
         bcnt <= bcnt + 1;
      if (cyc == LIMIT) begin
         bad_count = bad_count + 1;
         end_sim;
      end
   end
   task wr(input [12:0] a, input [31:0] v);
      bus_u.xfer(1'b1, a, v, q);
   endtask
   task rd(input [12:0] a);
      bus_u.xfer(1'b0, a, 32'h0, q);
   endtask
   task chk(input [31:0] g, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   // Runs one command and waits until busy has risen and fallen
   task cmd(input [31:0] c);
      begin
         bcnt = 0;
         wr(`STX_A_CMD, c);
         while (bsy !== 1'b0 || bcnt == 0) @(posedge clk_sys_i);
      end
   endtask
   function [9:0] taddr(input [3:0] o, input [1:0] h, g, input [7:0] t);
      taddr = (o == `STX_OP_TBPAGED) ? {h, t} :
              (o == `STX_OP_TBCUR) ? {g, t} : {`STX_LAST_PAGE, t};
   endfunction
   function skipf(input [3:0] o, input [7:0] b, input [2:0] n);
      skipf = (o == 4'h2 || o == 4'h3) ? (b == 8'h00) :
              (o == 4'h4) ? !b[n] : 1'b0;
   endfunction
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      bad_count = 0;
      num_checks = 0;
      cyc = 0;
      bcnt = 0;
      la = 8'h00;
      q = $urandom(32'hac7f);
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (i = 1; i < 9; i = i + 1) begin
         rd({i[10:0], 2'b00});
         chk(q, 32'h0);
      end
      rd(13'h0800);
      chk(q, 32'h0);
      $display("test 1 done");
      for (k = 0; k < 40; k = k + 1) begin
         op = $urandom % 10 + 1;
         // Unused opcodes only spend one instruction cycle
         if (k < 2)
            op = k[0] ? 4'h0 : 4'hf;
         {acc, imm, d, tp} = $urandom;
         q = $urandom;
         {ma, bi, ph, pg, z} = q[13:0];
         r = $urandom % 4;
         if (r == 0)
            d = 8'h00;
         if (r == 1) begin
            acc = d;
            imm = d;
         end
         wr(`STX_A_DMEM_LO + {ma, 2'b00}, {24'h0, d});
         wr(`STX_A_ACC, {24'h0, acc});
         wr(`STX_A_STAT, {31'h0, z});
         wr(`STX_A_TPLO, {24'h0, tp});
         wr(`STX_A_TPHI, {30'h0, ph});
         wr(`STX_A_PAGE, {30'h0, pg});
         for (i = 5; i < 8; i = i + 1) begin
            pa = taddr(i[3:0], ph, pg, tp);
            q = $urandom;
            pm[pa] = q[15:0];
            wr(`STX_A_PMEM_LO + {pa, 2'b00}, {16'h0, q[15:0]});
         end
         cmd({8'h00, imm, 1'b0, bi, 2'b00, ma, op});
         exa = acc;
         exd = d;
         exz = z;
         exs = skipf(op, d, bi);
         case (op)
            4'h1: exa = {d[3:0], d[7:4]};
            4'h3: exa = d;
            4'h5, 4'h6, 4'h7: begin
               pw = pm[taddr(op, ph, pg, tp)];
               exd = pw[7:0];
               la = pw[15:8];
            end
            4'h8: exa = acc ^ d;
            4'h9: exd = acc ^ d;
            4'ha: exa = acc ^ imm;
            default: ;
         endcase
         if (op == 4'h9)
            exz = (exd == 8'h00);
         else if (op == 4'h8 || op == 4'ha)
            exz = (exa == 8'h00);
         chk(bcnt, exs ? 8 : 4);
         chk({31'h0, skp}, {31'h0, exs});
         rd(`STX_A_ACC);
         chk(q, {24'h0, exa});
         rd(`STX_A_STAT);
         chk(q, {29'h0, 1'b0, exs, exz});
         rd(`STX_A_DMEM_LO + {ma, 2'b00});
         chk(q, {24'h0, exd});
         rd(`STX_A_TLATCH);
         chk(q, {24'h0, la});
      end
      $display("test 2 done");
      // Writes during a skipped command are ignored
      wr(`STX_A_DMEM_LO, 32'h0);
      wr(`STX_A_ACC, 32'h33);
      wr(`STX_A_STAT, 32'h0);
      wr(`STX_A_CMD, {28'h0, `STX_OP_CPSKIP});
      wr(`STX_A_ACC, 32'hff);
      wr(`STX_A_CMD, {16'h0011, 12'h0, `STX_OP_XORIMM});
      while (bsy !== 1'b0) @(posedge clk_sys_i);
      rd(`STX_A_ACC);
      chk(q, 32'h0);
      rd(`STX_A_STAT);
      chk(q, 32'h2);
      $display("test 3 done");
      end_sim;
   end
endmodule // testbench
